// file: rtl/cfg_loader_pkg.sv
// Constants and types shared by the configuration mode controller.
// Assumes a single 25 MHz clock domain.
package cfg_loader_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  // Longest reconfiguration time, in milliseconds.
  localparam int unsigned RECONFIG_MAX_MS = 100;
  // Longest time rounds down to whole cycles.
  localparam int unsigned RECONFIG_MAX_CYC = (RECONFIG_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned IO_PINS = 8;
  localparam int unsigned LEN_W = 16;
  localparam logic [LEN_W-1:0] CFG_LEN_DEFAULT = 16'h0040;
  localparam int unsigned TMR_W = 22;
  localparam logic [1:0] INIT_RESET_CYC = 2'h2;

  typedef enum logic [1:0] {
    SCHEME_MEMORY,
    SCHEME_PASSIVE_SERIAL_LOAD,
    SCHEME_PASSIVE_SERIAL_UNCLOCKED_LOAD,
    SCHEME_RESERVED
  } scheme_t;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_LOAD,
    ST_INIT_RESET,
    ST_INIT_IO,
    ST_USER
  } mode_state_t;

endpackage : cfg_loader_pkg

// file: rtl/cfg_shift_capture.sv
// Serial capture of the configuration stream into volatile storage.
// Assumes bit strobes and data are synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module cfg_shift_capture
  import cfg_loader_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Control.
  input wire logic clear_in,
  input wire logic accept_in,
  // Stream.
  input wire logic bit_valid_in,
  input wire logic bit_in,
  // Status.
  output logic [LEN_W-1:0] count_out,
  output logic [7:0] last_byte_out
);

  typedef struct packed {
    logic [LEN_W-1:0] cnt;
    logic [7:0] shreg;
  } cap_state_t;

  cap_state_t state_ff;
  cap_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (clear_in) begin
      nxt_state = '0;
    end else if (accept_in && bit_valid_in) begin
      nxt_state.shreg = {state_ff.shreg[6:0], bit_in};
      nxt_state.cnt = state_ff.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign count_out = state_ff.cnt;
  assign last_byte_out = state_ff.shreg;

endmodule // cfg_shift_capture
`default_nettype wire

// file: rtl/cfg_mode_control.sv
// Command/user mode controller for a volatile-configuration logic device.
// Assumes one 25 MHz clock; all pin inputs are synchronous to it.
//
// Overview of operation
// - Volatile configuration; full load after every power-up.
// - After load: reset registers, enable I/O, run.
// - User I/O high impedance until one cycle before configuration done.
// - Two top modes: command and user.
// - Reconfigure pin forces command mode, reload, resume.
// - Reconfiguration running past 100 ms raises the late flag.
// - Exactly three configuration schemes accepted.
// - Managed loads start automatically at power-up.
`timescale 1ns/1ps
`default_nettype none
module cfg_mode_control
  import cfg_loader_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Configuration pins.
  input wire logic chain_enable_in_n,
  input wire logic reconfig_n_in,
  input wire logic [1:0] scheme_in,
  input wire logic [LEN_W-1:0] cfg_len_in,
  input wire logic cfg_bit_valid_in,
  input wire logic cfg_bit_in,
  // Configuration status.
  output logic chain_enable_out_n,
  output logic user_mode_out,
  output logic cfg_done_out,
  output logic cfg_error_out,
  output logic reconfig_late_out,
  // User logic side.
  output logic user_reg_reset_out,
  output logic [IO_PINS-1:0] io_oe_n_out
);

  typedef struct packed {
    mode_state_t st;
    logic chain_n;
    logic user;
    logic done;
    logic err;
    logic late;
    logic reg_rst;
    logic [IO_PINS-1:0] oe_n;
    logic [1:0] init_cnt;
    logic [TMR_W-1:0] tmr;
    logic tmr_run;
    logic [LEN_W-1:0] len;
  } ctl_state_t;

  ctl_state_t state_ff;
  ctl_state_t nxt_state;
  logic [LEN_W-1:0] bit_count;
  logic cap_clear;
  logic cap_accept;

  // True for the three supported configuration schemes only.
  function automatic logic scheme_ok(input logic [1:0] s);
    return (s != SCHEME_RESERVED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // Clear the store on entry into loading so a reload starts from nothing.
  assign cap_clear = (state_ff.st == ST_POWERUP);
  // Data counts only while loading and selected by the chain input.
  assign cap_accept = (state_ff.st == ST_LOAD) && !chain_enable_in_n;

  cfg_shift_capture u_capture (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .clear_in(cap_clear),
    .accept_in(cap_accept),
    .bit_valid_in(cfg_bit_valid_in),
    .bit_in(cfg_bit_in),
    .count_out(bit_count),
    .last_byte_out()
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_state = state_ff;
    if (state_ff.tmr_run) begin
      nxt_state.tmr = state_ff.tmr + 22'h000001;
      if (state_ff.tmr == TMR_W'(RECONFIG_MAX_CYC)) begin
        nxt_state.late = 1'b1;
      end
    end
    if (!reconfig_n_in && state_ff.st != ST_POWERUP) begin
      // Forcing back to command mode drops user state at once.
      nxt_state.st = ST_POWERUP;
      nxt_state.user = 1'b0;
      nxt_state.done = 1'b0;
      nxt_state.chain_n = 1'b1;
      nxt_state.oe_n = '1;
      nxt_state.reg_rst = 1'b1;
      nxt_state.tmr = '0;
      nxt_state.tmr_run = 1'b1;
      // A timeout landing in the same cycle as a new pull is still reported.
      nxt_state.late = state_ff.tmr_run && (state_ff.tmr == TMR_W'(RECONFIG_MAX_CYC));
    end else begin
      case (state_ff.st)
        ST_POWERUP: begin
          // Loading begins without any request, once the pin is released.
          if (reconfig_n_in) begin
            nxt_state.st = ST_LOAD;
            nxt_state.len = cfg_len_in;
            nxt_state.err = !scheme_ok(scheme_in);
          end
        end
        ST_LOAD: begin
          // An unsupported scheme never loads, so the device stays in command mode.
          if (!state_ff.err && bit_count >= state_ff.len && state_ff.len != '0) begin
            nxt_state.st = ST_INIT_RESET;
            nxt_state.chain_n = 1'b0;
            nxt_state.reg_rst = 1'b1;
            nxt_state.init_cnt = INIT_RESET_CYC;
          end
        end
        ST_INIT_RESET: begin
          nxt_state.init_cnt = state_ff.init_cnt - 2'h1;
          if (state_ff.init_cnt == 2'h1) begin
            nxt_state.st = ST_INIT_IO;
            nxt_state.reg_rst = 1'b0;
            nxt_state.oe_n = '0;
          end
        end
        ST_INIT_IO: begin
          nxt_state.st = ST_USER;
          nxt_state.user = 1'b1;
          nxt_state.done = 1'b1;
          nxt_state.tmr_run = 1'b0;
        end
        ST_USER: begin
          nxt_state.user = 1'b1;
        end
        default: begin
          nxt_state.st = ST_POWERUP;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff.st <= ST_POWERUP;
      state_ff.chain_n <= 1'b1;
      state_ff.user <= 1'b0;
      state_ff.done <= 1'b0;
      state_ff.err <= 1'b0;
      state_ff.late <= 1'b0;
      state_ff.reg_rst <= 1'b1;
      state_ff.oe_n <= '1;
      state_ff.init_cnt <= '0;
      state_ff.tmr <= '0;
      state_ff.tmr_run <= 1'b0;
      state_ff.len <= CFG_LEN_DEFAULT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign chain_enable_out_n = state_ff.chain_n;
  assign user_mode_out = state_ff.user;
  assign cfg_done_out = state_ff.done;
  assign cfg_error_out = state_ff.err;
  assign reconfig_late_out = state_ff.late;
  assign user_reg_reset_out = state_ff.reg_rst;
  assign io_oe_n_out = state_ff.oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_hiz_cmd;
    @(posedge clk_in) disable iff (!arst_n_in)
    !user_mode_out && state_ff.st != ST_INIT_IO |-> io_oe_n_out == '1;
  endproperty
  io_hiz_cmd_a: assert property (p_hiz_cmd) else $error("I/O driven in command mode.");

  user_io_on_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    user_mode_out |-> io_oe_n_out == '0 && !user_reg_reset_out) else $error("User mode without I/O.");

  // A reconfiguration pull may cut the initialisation short, so the pin disables this check.
  init_order_a: assert property (@(posedge clk_in) disable iff (!arst_n_in || !reconfig_n_in)
    $fell(chain_enable_out_n) |-> user_reg_reset_out [*2] ##1
    (!user_reg_reset_out && io_oe_n_out == '0) ##1 user_mode_out) else $error("Init order wrong.");

  force_cmd_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !reconfig_n_in |=> !user_mode_out && io_oe_n_out == '1) else $error("Reconfig not forced.");

  chain_ignore_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    chain_enable_in_n |=> $stable(bit_count) || bit_count == '0) else $error("Data taken while deselected.");

  chain_out_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $fell(chain_enable_out_n) |-> $past(state_ff.st) == ST_LOAD && bit_count >= state_ff.len)
    else $error("Chain released early.");

  bad_scheme_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    cfg_error_out |-> !user_mode_out && chain_enable_out_n) else $error("Bad scheme loaded.");

  auto_start_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_ff.st == ST_POWERUP && reconfig_n_in |=> state_ff.st == ST_LOAD) else $error("No automatic start.");

  late_flag_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(reconfig_late_out) |-> $past(state_ff.tmr_run) && $past(state_ff.tmr) == TMR_W'(RECONFIG_MAX_CYC))
    else $error("Late flag off.");

  load_done_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_ff.st == ST_LOAD && !cfg_error_out && state_ff.len != '0 && bit_count >= state_ff.len && reconfig_n_in
    |=> state_ff.st == ST_INIT_RESET && !chain_enable_out_n) else $error("Load did not complete.");

  reach_user_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(user_mode_out));
  reconfig_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) user_mode_out ##1 !user_mode_out);
  chain_wait_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
    state_ff.st == ST_LOAD && chain_enable_in_n && cfg_bit_valid_in);
  bad_scheme_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(cfg_error_out));

endmodule // cfg_mode_control
`default_nettype wire

// file: test/cfg_stream_source.sv
// Serial stream source standing in for the configuration memory or host.
// Assumes the receiver samples the stream on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module cfg_stream_source (
  // Clock.
  input wire logic clk_in,
  // Stream.
  output logic valid_out,
  output logic bit_out
);
  logic sending = 1'b0;
  initial begin
    valid_out = 1'b0;
    bit_out = 1'b0;
  end
  // The idle data line toggles so a stale bit never passes for a fresh one.
  always @(posedge clk_in) begin
    #1;
    if (!sending) begin
      bit_out = ~bit_out;
    end
  end
  // Pushes n bits, optionally stalling gap cycles after each bit but the last.
  task automatic send(input int n, input int gap);
    sending = 1'b1;
    for (int i = 0; i < n; i++) begin
      valid_out = 1'b1;
      bit_out = i[0] ^ i[3];
      @(posedge clk_in);
      #1;
      // No stall after the last bit, so the caller resumes one step after the edge that takes it.
      if (gap != 0 && i != n - 1) begin
        valid_out = 1'b0;
        bit_out = ~bit_out;
        repeat (gap) @(posedge clk_in);
        #1;
      end
    end
    valid_out = 1'b0;
    sending = 1'b0;
  endtask
endmodule // cfg_stream_source
`default_nettype wire

// file: test/sram_config_mode_control_test.sv
// Self-checking bench for the configuration mode controller.
// Assumes the stream source model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module sram_config_mode_control_test
  import cfg_loader_pkg::*;
;
  typedef struct {logic [1:0] scheme; int len; int gap; logic err;} row_t;
  row_t rows[4] = '{'{2'h0, 16, 0, 1'b0}, '{2'h1, 8, 2, 1'b0}, '{2'h2, 1, 0, 1'b0}, '{2'h3, 8, 0, 1'b1}};
  logic clk_in, arst_n_in, chain_enable_in_n, reconfig_n_in, cfg_bit_valid_in, cfg_bit_in;
  logic [1:0] scheme_in;
  logic [LEN_W-1:0] cfg_len_in;
  logic chain_enable_out_n, user_mode_out, cfg_done_out, cfg_error_out, reconfig_late_out, user_reg_reset_out;
  logic [IO_PINS-1:0] io_oe_n_out;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  cfg_mode_control DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .chain_enable_in_n(chain_enable_in_n),
    .reconfig_n_in(reconfig_n_in), .scheme_in(scheme_in), .cfg_len_in(cfg_len_in),
    .cfg_bit_valid_in(cfg_bit_valid_in), .cfg_bit_in(cfg_bit_in), .chain_enable_out_n(chain_enable_out_n),
    .user_mode_out(user_mode_out), .cfg_done_out(cfg_done_out), .cfg_error_out(cfg_error_out),
    .reconfig_late_out(reconfig_late_out), .user_reg_reset_out(user_reg_reset_out), .io_oe_n_out(io_oe_n_out));
  cfg_stream_source src (.clk_in(clk_in), .valid_out(cfg_bit_valid_in), .bit_out(cfg_bit_in));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // The ceiling is several times the expected run, so only a hang reaches it.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] sch, input int len);
    arst_n_in = 1'b0;
    scheme_in = sch;
    cfg_len_in = len[LEN_W-1:0];
    repeat (12) @(posedge clk_in);
    #1 arst_n_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // Called one step after the edge that takes the last bit.
  task automatic expect_finish();
    @(posedge clk_in);
    #1;
    // The chain output is what the next device of a chain sees on its chain input.
    check("chain_out_n", 8'h00, {7'h0, chain_enable_out_n});
    check("io_oe_n", 8'hFF, io_oe_n_out);
    check("reg_reset", 8'h01, {7'h0, user_reg_reset_out});
    repeat (2) @(posedge clk_in);
    #1;
    check("io_oe_n", 8'h00, io_oe_n_out);
    check("user_mode", 8'h00, {7'h0, user_mode_out});
    @(posedge clk_in);
    #1;
    check("user_mode", 8'h01, {7'h0, user_mode_out});
    check("done", 8'h01, {7'h0, cfg_done_out});
    check("reg_reset", 8'h00, {7'h0, user_reg_reset_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n_in = 1'b0;
    chain_enable_in_n = 1'b0;
    reconfig_n_in = 1'b1;
    scheme_in = 2'h0;
    cfg_len_in = '0;
    foreach (rows[r]) begin
      do_reset(rows[r].scheme, rows[r].len);
      check("chain_out_n", 8'h01, {7'h0, chain_enable_out_n});
      check("io_oe_n", 8'hFF, io_oe_n_out);
      src.send(rows[r].len, rows[r].gap);
      if (rows[r].err) begin
        repeat (8) @(posedge clk_in);
        #1;
        check("error", 8'h01, {7'h0, cfg_error_out});
        check("user_mode", 8'h00, {7'h0, user_mode_out});
        check("chain_out_n", 8'h01, {7'h0, chain_enable_out_n});
      end else begin
        check("error", 8'h00, {7'h0, cfg_error_out});
        expect_finish();
      end
    end
    // Data while the chain input is high must be ignored.
    do_reset(2'h1, 8);
    chain_enable_in_n = 1'b1;
    src.send(8, 0);
    repeat (6) @(posedge clk_in);
    #1;
    check("user_mode", 8'h00, {7'h0, user_mode_out});
    check("chain_out_n", 8'h01, {7'h0, chain_enable_out_n});
    chain_enable_in_n = 1'b0;
    src.send(8, 0);
    expect_finish();
    // One bit short of the length leaves the device in command mode.
    do_reset(2'h0, 8);
    src.send(7, 0);
    repeat (6) @(posedge clk_in);
    #1;
    check("user_mode", 8'h00, {7'h0, user_mode_out});
    check("io_oe_n", 8'hFF, io_oe_n_out);
    src.send(1, 0);
    expect_finish();
    // Reconfiguration from user mode through the dedicated pin.
    reconfig_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("user_mode", 8'h00, {7'h0, user_mode_out});
    check("io_oe_n", 8'hFF, io_oe_n_out);
    check("chain_out_n", 8'h01, {7'h0, chain_enable_out_n});
    check("reg_reset", 8'h01, {7'h0, user_reg_reset_out});
    reconfig_n_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    src.send(8, 1);
    expect_finish();
    check("late", 8'h00, {7'h0, reconfig_late_out});
    print_verdict();
  end
endmodule // sram_config_mode_control_test
`default_nettype wire
